// [rtl/sleep_wake_pkg.sv]
// Shared constants and carrier types for the sleep, wake and thermal controller.
// Assumes a 100 MHz system clock; all timing counts are derived here.
package sleep_wake_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned INT_BASE_MS      = 32;
  localparam int unsigned SCAN_BASE_US     = 1000;
  localparam int unsigned SCAN_WINDOW_US   = 125;
  localparam int unsigned WET_TIME_MS      = 20;
  localparam int unsigned INT_BASE_CYC     = INT_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned SCAN_BASE_CYC    = SCAN_BASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SCAN_WINDOW_CYC  = SCAN_WINDOW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WET_CYC          = WET_TIME_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int unsigned FRAME_BITS       = 24;
  localparam logic [7:0]  OP_SLEEP         = 8'h0c;
  localparam int unsigned OP_MSB           = 23;
  localparam int unsigned OP_LSB           = 16;
  localparam int unsigned INT_FIELD_MSB    = 5;
  localparam int unsigned INT_FIELD_LSB    = 3;
  localparam int unsigned SCAN_FIELD_MSB   = 2;
  localparam int unsigned SCAN_FIELD_LSB   = 0;
  localparam logic [2:0]  INT_CODE_RST     = 3'h0;
  localparam logic [2:0]  SCAN_CODE_RST    = 3'h0;
  localparam int unsigned N_INPUTS         = 22;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_SCAN
  } power_mode_e;

  typedef struct packed {
    logic [2:0] int_code;
    logic [2:0] scan_code;
  } sleep_timers_s;

  typedef struct packed {
    logic thermal_flag;
    logic int_flag;
  } so_flags_s;

endpackage : sleep_wake_pkg

// [rtl/wet_timer.sv]
// One wetting-current timer per input for metallic contacts.
// Assumes closed and settings come from logic on sys_clk.
`timescale 1ns/1ns
module wet_timer #(
  parameter int unsigned WET_CYCLES = 2_000_000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic closed,
  input  wire logic metallic,
  input  wire logic timer_en,
  output logic      high_current
);
  localparam int unsigned CW = $clog2(WET_CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          hi_q;
  logic          hi_d;

  always_comb begin
    cnt_d = cnt_q;
    hi_d  = 1'b0;
    if (!closed) begin
      cnt_d = '0;
    end else if (cnt_q != CW'(WET_CYCLES)) begin
      cnt_d = cnt_q + CW'(1);
    end
    if (metallic && closed) begin
      if (!timer_en) begin
        hi_d = 1'b1;
      end else begin
        hi_d = (cnt_q != CW'(WET_CYCLES));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      hi_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hi_q  <= hi_d;
    end
  end

  assign high_current = hi_q;

endmodule : wet_timer

// [rtl/sleep_wake_ctrl.sv]
// Sleep, wake, scan and thermal controller of a multi-input switch monitor.
// Assumes SPI pins, wake and temperature lines are asynchronous to sys_clk;
// the 24-bit shift register is sampled on SCK rising edges found by sys_clk.
`timescale 1ns/1ns

// Notes on behaviour
// - Only a complete valid sleep command frame puts the device asleep.
// - Configuration held in registers stays unchanged while asleep.
// - Wake on input change, interrupt timer, wake pin, interrupt pin, chip select, reset.
// - Interrupt and chip-select wake need logic supply; interrupt wake needs wake pin high.
// - First serial output frame after a chip-select wake is invalid.
// - Sleep opcode 0x0c in bits 23:16, interrupt timer 5:3, scan timer 2:0.
// - Interrupt timer 32 ms doubling to 4.096 s; expiry raises interrupt and wakes.
// - Scan timer code 0 disables; 1 ms doubling to 64 ms.
// - On scan expiry inputs are active for about 125 us to sample switches.
// - Sampled states differing from pre-sleep states interrupt and wake when enabled.
// - No change restarts scan timer, tri-states inputs, stays asleep.
// - Both sleep timers are held inactive in normal operation.
// - Thermal monitor acts only in normal operation.
// - Over-temperature raises interrupt, forces 16 mA sources to 2 mA, sets flag.
// - Thermal flag clears on chip-select rise only when temperature is below limit.
// - Once cool, programmed current-source settings are used again.
// - Metallic inputs with timer enabled get high current for first 20 ms.
// - Metallic inputs with timer disabled get high current while closed.
// - Interrupt output stays low until host acknowledges with a serial transfer.
// - Closure while chip select is low keeps interrupt at the next chip-select rise.
module sleep_wake_ctrl
  import sleep_wake_pkg::*;
#(
  parameter int unsigned NIN      = N_INPUTS,
  parameter int unsigned INT_BASE = INT_BASE_CYC,
  parameter int unsigned SCAN_BASE = SCAN_BASE_CYC,
  parameter int unsigned WET_CYCLES = WET_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          cs_n,
  input  wire logic                          sck,
  input  wire logic                          mosi,
  input  wire logic                          wake_n,
  input  wire logic                          int_pin_n,
  input  wire logic                          vdd_present,
  input  wire logic                          over_temp,
  input  wire logic [NIN-1:0]                switch_closed,
  input  wire logic [NIN-1:0]                int_enable,
  input  wire logic [NIN-1:0]                metallic,
  input  wire logic [NIN-1:0]                wet_timer_en,
  input  wire logic [NIN-1:0]                high_current_cfg,
  output logic                               int_out_n,
  output logic                               int_oe_n,
  output logic                               asleep,
  output logic                               inputs_active,
  output logic                               so_frame_invalid,
  output sleep_wake_pkg::so_flags_s          so_flags,
  output logic [NIN-1:0]                     current_16ma,
  output logic [NIN-1:0]                     wet_high
);

  // ****************************************************************
  // Synchronisers for pins from outside the clock domain
  // ****************************************************************
  localparam int unsigned NS = 8 + NIN;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {NS{1'b1}};
      sync_q <= {NS{1'b1}};
    end else begin
      meta_q <= {cs_n, sck, mosi, wake_n, int_pin_n, vdd_present ^ 1'b1, over_temp ^ 1'b1,
                 ~switch_closed, 1'b1};
      sync_q <= meta_q;
    end
  end

  logic           cs_s, sck_s, mosi_s, wake_s, intp_s, vdd_s, hot_s;
  logic [NIN-1:0] sw_s;
  assign cs_s   = sync_q[NS-1];
  assign sck_s  = sync_q[NS-2];
  assign mosi_s = sync_q[NS-3];
  assign wake_s = sync_q[NS-4];
  assign intp_s = sync_q[NS-5];
  assign vdd_s  = ~sync_q[NS-6];
  assign hot_s  = ~sync_q[NS-7];
  assign sw_s   = ~sync_q[NS-8 -: NIN];

  // ****************************************************************
  // Edge history and serial frame capture
  // ****************************************************************
  logic                  cs_p_q, sck_p_q, wake_p_q, intp_p_q;
  logic [FRAME_BITS-1:0] shift_q, shift_d;
  logic [4:0]            bits_q, bits_d;
  logic                  cs_fall, cs_rise, sck_rise, wake_fall, intp_fall;

  assign cs_fall   = cs_p_q & ~cs_s;
  assign cs_rise   = ~cs_p_q & cs_s;
  assign sck_rise  = ~sck_p_q & sck_s;
  assign wake_fall = wake_p_q & ~wake_s;
  assign intp_fall = intp_p_q & ~intp_s;

  always_comb begin
    shift_d = shift_q;
    bits_d  = bits_q;
    if (cs_fall) begin
      bits_d = '0;
    end else if (!cs_s && sck_rise) begin
      shift_d = {shift_q[FRAME_BITS-2:0], mosi_s};
      if (bits_q != 5'(FRAME_BITS + 1)) begin
        bits_d = bits_q + 5'h01;
      end
    end
  end

  logic sleep_cmd;
  assign sleep_cmd = cs_rise && (bits_q == 5'(FRAME_BITS))
                     && (shift_q[OP_MSB:OP_LSB] == OP_SLEEP);

  // ****************************************************************
  // Mode, timers and scan
  // ****************************************************************
  power_mode_e    mode_q, mode_d;
  sleep_timers_s  tmr_q, tmr_d;
  logic [31:0]    int_cnt_q, int_cnt_d;
  logic [31:0]    scan_cnt_q, scan_cnt_d;
  logic [NIN-1:0] ref_q, ref_d;
  logic [NIN-1:0] sw_prev_q;
  logic           int_q, int_d;
  logic           therm_q, therm_d;
  logic           closure_in_frame_q, closure_in_frame_d;
  logic           invalid_q, invalid_d;
  logic           wake_evt;
  logic [31:0]    int_period, scan_period;

  function automatic logic [31:0] period_of(input logic [31:0] base, input logic [2:0] sh);
    period_of = base << sh;
  endfunction : period_of

  assign int_period  = period_of(32'(INT_BASE), tmr_q.int_code);
  assign scan_period = period_of(32'(SCAN_BASE), tmr_q.scan_code - 3'h1);

  assign wake_evt = wake_fall
                  || (intp_fall && vdd_s && wake_s)
                  || (cs_fall && vdd_s);

  always_comb begin
    mode_d             = mode_q;
    tmr_d              = tmr_q;
    int_cnt_d          = '0;
    scan_cnt_d         = '0;
    ref_d              = ref_q;
    int_d              = int_q;
    therm_d            = therm_q;
    closure_in_frame_d = closure_in_frame_q;
    invalid_d          = invalid_q;
    if (!cs_s && |(sw_s & ~sw_prev_q)) begin
      closure_in_frame_d = 1'b1;
    end
    unique case (mode_q)
      MODE_NORMAL: begin
        if (cs_rise) begin
          if (!hot_s) begin
            therm_d = 1'b0;
          end
          if (!closure_in_frame_d) begin
            int_d = 1'b0;
          end
          closure_in_frame_d = 1'b0;
          invalid_d          = 1'b0;
        end
        // Events are applied after the clear, so one that lands on the clearing edge is never lost.
        if (|((sw_s ^ sw_prev_q) & int_enable)) begin
          int_d = 1'b1;
        end
        if (hot_s) begin
          therm_d = 1'b1;
          if (!therm_q) begin
            int_d = 1'b1;
          end
        end
        if (sleep_cmd) begin
          mode_d          = MODE_SLEEP;
          tmr_d.int_code  = shift_q[INT_FIELD_MSB:INT_FIELD_LSB];
          tmr_d.scan_code = shift_q[SCAN_FIELD_MSB:SCAN_FIELD_LSB];
          ref_d           = sw_s;
        end
      end
      MODE_SLEEP, MODE_SCAN: begin
        int_cnt_d = int_cnt_q + 32'h1;
        if (mode_q == MODE_SLEEP) begin
          if (tmr_q.scan_code != SCAN_CODE_RST) begin
            scan_cnt_d = scan_cnt_q + 32'h1;
          end
          if (scan_cnt_d >= scan_period) begin
            mode_d     = MODE_SCAN;
            scan_cnt_d = '0;
          end
        end else begin
          scan_cnt_d = scan_cnt_q + 32'h1;
          if (scan_cnt_q >= 32'(SCAN_WINDOW_CYC - 1)) begin
            scan_cnt_d = '0;
            if (|((sw_s ^ ref_q) & int_enable)) begin
              mode_d = MODE_NORMAL;
              int_d  = 1'b1;
            end else begin
              mode_d = MODE_SLEEP;
            end
          end
        end
        if (int_cnt_d >= int_period) begin
          mode_d = MODE_NORMAL;
          int_d  = 1'b1;
        end
        if (wake_evt) begin
          mode_d = MODE_NORMAL;
          if (cs_fall && vdd_s) begin
            invalid_d = 1'b1;
          end
        end
      end
      default: mode_d = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_p_q             <= 1'b1;
      sck_p_q            <= 1'b1;
      wake_p_q           <= 1'b1;
      intp_p_q           <= 1'b1;
      shift_q            <= '0;
      bits_q             <= '0;
      mode_q             <= MODE_NORMAL;
      tmr_q              <= '{int_code: INT_CODE_RST, scan_code: SCAN_CODE_RST};
      int_cnt_q          <= '0;
      scan_cnt_q         <= '0;
      ref_q              <= '0;
      sw_prev_q          <= '0;
      int_q              <= 1'b0;
      therm_q            <= 1'b0;
      closure_in_frame_q <= 1'b0;
      invalid_q          <= 1'b0;
    end else begin
      cs_p_q             <= cs_s;
      sck_p_q            <= sck_s;
      wake_p_q           <= wake_s;
      intp_p_q           <= intp_s;
      shift_q            <= shift_d;
      bits_q             <= bits_d;
      mode_q             <= mode_d;
      tmr_q              <= tmr_d;
      int_cnt_q          <= int_cnt_d;
      scan_cnt_q         <= scan_cnt_d;
      ref_q              <= ref_d;
      sw_prev_q          <= sw_s;
      int_q              <= int_d;
      therm_q            <= therm_d;
      closure_in_frame_q <= closure_in_frame_d;
      invalid_q          <= invalid_d;
    end
  end

  // ****************************************************************
  // Current sources and registered outputs
  // ****************************************************************
  // Settings live in the caller's registers and are only gated here, so
  // sleeping or overheating never rewrites them.
  logic [NIN-1:0] wet_raw;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_wet
      wet_timer #(
        .WET_CYCLES (WET_CYCLES)
      ) u_wet (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .closed       (sw_s[gi]),
        .metallic     (metallic[gi]),
        .timer_en     (wet_timer_en[gi]),
        .high_current (wet_raw[gi])
      );
    end
  endgenerate

  logic           out_int_n_q, out_asleep_q, out_active_q, out_inv_q;
  so_flags_s      out_flags_q;
  logic [NIN-1:0] out_16_q, out_wet_q;
  logic           awake_d;
  logic           hot_gate;
  assign awake_d = (mode_d != MODE_SLEEP);
  // The live temperature, not the sticky flag, gates the sources, so drive returns as soon as the die cools.
  assign hot_gate = hot_s && (mode_d == MODE_NORMAL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_int_n_q  <= 1'b1;
      out_asleep_q <= 1'b0;
      out_active_q <= 1'b1;
      out_inv_q    <= 1'b0;
      out_flags_q  <= '0;
      out_16_q     <= '0;
      out_wet_q    <= '0;
    end else begin
      out_int_n_q  <= ~int_d;
      out_asleep_q <= (mode_d != MODE_NORMAL);
      out_active_q <= awake_d;
      out_inv_q    <= invalid_d;
      out_flags_q  <= '{thermal_flag: therm_d, int_flag: int_d};
      out_16_q     <= (hot_gate ? '0 : high_current_cfg) & {NIN{awake_d}};
      out_wet_q    <= (hot_gate ? '0 : wet_raw) & {NIN{awake_d}};
    end
  end

  assign int_out_n        = out_int_n_q;
  assign int_oe_n         = out_int_n_q; // Open drain: drive only while low.
  assign asleep           = out_asleep_q;
  assign inputs_active    = out_active_q;
  assign so_frame_invalid = out_inv_q;
  assign so_flags         = out_flags_q;
  assign current_16ma     = out_16_q;
  assign wet_high         = out_wet_q;

endmodule : sleep_wake_ctrl

// [verif/sleep_wake_chk.sv]
// Checker for the sleep, wake and thermal controller.
// Assumes it is bound to sleep_wake_ctrl and sees only its ports.
`timescale 1ns/1ns
module sleep_wake_chk
  import sleep_wake_pkg::*;
#(
  parameter int unsigned NIN = N_INPUTS
) (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     cs_n,
  input wire logic                     vdd_present,
  input wire logic                     over_temp,
  input wire logic                     int_out_n,
  input wire logic                     int_oe_n,
  input wire logic                     asleep,
  input wire logic                     inputs_active,
  input wire logic                     so_frame_invalid,
  input wire sleep_wake_pkg::so_flags_s so_flags,
  input wire logic [NIN-1:0]           current_16ma
);
  import sleep_wake_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_scan_start;
    asleep && !inputs_active ##1 asleep && inputs_active;
  endsequence
  a_entry_cs_high: assert property ($rose(asleep) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("asleep rose without chip select high");
  a_oe_follows: assert property (int_oe_n == int_out_n)
    else $error("interrupt enable differs from level");
  a_active_awake: assert property (!asleep |-> inputs_active)
    else $error("inputs idle while awake");
  a_hot_low_drive: assert property ((over_temp && !asleep) [*5] |-> current_16ma == '0)
    else $error("high current kept while hot");
  a_flag_clear_cool: assert property ($fell(so_flags.thermal_flag) |-> cs_n && !$past(over_temp, 3))
    else $error("thermal flag cleared while hot or without chip select");
  a_no_heat_asleep: assert property (asleep && $past(asleep) |-> !$rose(so_flags.thermal_flag))
    else $error("thermal flag set while asleep");
  a_invalid_cs_wake: assert property ($rose(so_frame_invalid) |-> !cs_n && vdd_present)
    else $error("frame marked invalid without chip select wake");
  a_int_release_cs: assert property ($rose(int_out_n) |-> cs_n)
    else $error("interrupt released while chip select low");
  a_scan_window: assert property (s_scan_start |=> inputs_active [*8])
    else $error("scan window too short");
endmodule : sleep_wake_chk

bind sleep_wake_ctrl sleep_wake_chk #(.NIN(NIN)) sleep_wake_chk_i (
  .sys_clk, .rst_n, .cs_n, .vdd_present, .over_temp, .int_out_n, .int_oe_n,
  .asleep, .inputs_active, .so_frame_invalid, .so_flags, .current_16ma
);

// [verif/host_spi.sv]
// Host controller model driving the serial link of the controller.
// Assumes sys_clk at 100 MHz; the link clock idles low and runs only in frames.
`timescale 1ns/1ns
module host_spi (
  input  wire logic sys_clk,
  output logic      cs_n,
  output logic      sck,
  output logic      mosi
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // Sends the top n bits of w; the data line shows the inverse once released.
  task automatic frame(input logic [23:0] w, input int n);
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    #40;
    for (int i = 23; i > 23 - n; i--) begin
      mosi = w[i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask : frame
endmodule : host_spi

// [verif/tb.sv]
// Self-checking bench for the sleep, wake and thermal controller.
// Assumes reduced timer parameters; the checker is bound to the design.
`timescale 1ns/1ns
module tb;
  import sleep_wake_pkg::*;
  localparam int unsigned INTB = 512;
  localparam int unsigned SCNB = 16;
  localparam int unsigned WETC = 32;
  logic sys_clk, rst_n, cs_n, sck, mosi, wake_n, ext_int_n, vdd_present, over_temp;
  logic int_out_n, int_oe_n, asleep, inputs_active, so_frame_invalid;
  logic [N_INPUTS-1:0] switch_closed, int_enable, metallic, wet_timer_en, high_current_cfg, current_16ma, wet_high;
  so_flags_s so_flags;
  int n_mismatch, checked, n;
  // The interrupt wire is open drain with a host pull-up.
  wire int_pin_n = int_oe_n & ext_int_n;

  sleep_wake_ctrl #(.INT_BASE(INTB), .SCAN_BASE(SCNB), .WET_CYCLES(WETC)) sleep_wake_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .mosi(mosi), .wake_n(wake_n),
    .int_pin_n(int_pin_n), .vdd_present(vdd_present), .over_temp(over_temp),
    .switch_closed(switch_closed), .int_enable(int_enable), .metallic(metallic),
    .wet_timer_en(wet_timer_en), .high_current_cfg(high_current_cfg), .int_out_n(int_out_n),
    .int_oe_n(int_oe_n), .asleep(asleep), .inputs_active(inputs_active),
    .so_frame_invalid(so_frame_invalid), .so_flags(so_flags), .current_16ma(current_16ma),
    .wet_high(wet_high));
  host_spi host_spi_i (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  function automatic logic pick(input int s);
    case (s)
      0: return asleep;
      1: return inputs_active;
      default: return int_out_n;
    endcase
  endfunction : pick
  task automatic wt(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (pick(s) !== v) begin
      cyc(1);
      k++;
      if (k > lim) begin
        n_mismatch++;
        $display("mismatch wait %0d expected %b seen %b", s, v, pick(s));
        conclude();
      end
    end
  endtask : wt
  task automatic go_sleep(input logic [2:0] ic, input logic [2:0] sc);
    host_spi_i.frame({OP_SLEEP, 10'h3ff, ic, sc}, 24);
    wt(0, 1'b1, 20, n);
  endtask : go_sleep
  // Sends an all-zero frame; its chip-select rise acknowledges the interrupt, and its fall wakes a sleeping device that has logic supply.
  task automatic ack();
    host_spi_i.frame(24'h0, 24);
    cyc(4);
  endtask : ack
  task automatic conclude();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ****************
  // Scenarios
  // ****************
  task automatic t_frames();
    chk("reset outs", {asleep, int_out_n, int_oe_n, inputs_active, so_frame_invalid, so_flags}, 7'b0111000);
    host_spi_i.frame({OP_SLEEP, 16'h0}, 23);
    cyc(20);
    chk("short frame", asleep, 1'b0);
    host_spi_i.frame({OP_SLEEP + 8'h01, 16'h0}, 24);
    cyc(20);
    chk("wrong opcode", asleep, 1'b0);
    $display("done frames");
  endtask : t_frames
  task automatic t_int_timer();
    go_sleep(3'h1, 3'h0);
    chk("idle inputs", inputs_active, 1'b0);
    wt(0, 1'b0, 2 * INTB + 20, n);
    chk("int period", n >= 2 * INTB - 10 && n <= 2 * INTB + 10, 1'b1);
    chk("int low", {int_out_n, so_flags.int_flag}, 2'b01);
    cyc(50);
    chk("int held", int_out_n, 1'b0);
    fork
      ack();
      begin
        cyc(100);
        switch_closed[0] = 1'b1;
      end
    join
    chk("int kept", int_out_n, 1'b0);
    ack();
    chk("int ack", int_out_n, 1'b1);
    $display("done int timer");
  endtask : t_int_timer
  task automatic t_scan();
    go_sleep(3'h7, 3'h1);
    wt(1, 1'b1, 40, n);
    chk("scan start", n >= SCNB - 4 && n <= SCNB + 4, 1'b1);
    wt(1, 1'b0, 13000, n);
    chk("scan window", n >= 12490 && n <= 12510, 1'b1);
    chk("still asleep", asleep, 1'b1);
    wt(1, 1'b1, 40, n);
    switch_closed[3] = 1'b1;
    wt(0, 1'b0, 13000, n);
    chk("change wake", {n >= 12490, int_out_n}, 2'b10);
    ack();
    $display("done scan");
  endtask : t_scan
  task automatic t_wake();
    go_sleep(3'h7, 3'h0);
    cyc(300);
    chk("no scan", inputs_active, 1'b0);
    wake_n = 1'b0;
    wt(0, 1'b0, 10, n);
    wake_n = 1'b1;
    go_sleep(3'h7, 3'h0);
    vdd_present = 1'b0;
    ack();
    chk("cs no supply", asleep, 1'b1);
    vdd_present = 1'b1;
    ext_int_n = 1'b0;
    wt(0, 1'b0, 10, n);
    ext_int_n = 1'b1;
    go_sleep(3'h7, 3'h0);
    fork
      ack();
      begin
        cyc(20);
        chk("cs wake", {asleep, so_frame_invalid}, 2'b01);
      end
    join
    $display("done wake");
  endtask : t_wake
  task automatic t_thermal();
    over_temp = 1'b1;
    cyc(10);
    chk("hot", {so_flags.thermal_flag, int_out_n, current_16ma == '0}, 3'b101);
    ack();
    chk("hot flag", so_flags.thermal_flag, 1'b1);
    over_temp = 1'b0;
    cyc(10);
    chk("cool drive", {so_flags.thermal_flag, current_16ma}, {1'b1, high_current_cfg});
    ack();
    chk("cool flag", {so_flags.thermal_flag, int_out_n}, 2'b01);
    go_sleep(3'h7, 3'h0);
    over_temp = 1'b1;
    cyc(20);
    chk("hot asleep", {so_flags.thermal_flag, int_out_n, asleep}, 3'b011);
    over_temp = 1'b0;
    wake_n = 1'b0;
    wt(0, 1'b0, 10, n);
    wake_n = 1'b1;
    $display("done thermal");
  endtask : t_thermal
  task automatic t_wet();
    metallic[5] = 1'b1;
    switch_closed[5] = 1'b1;
    cyc(5);
    chk("wet on", wet_high[5], 1'b1);
    cyc(WETC + 5);
    chk("wet off", wet_high[5], 1'b0);
    metallic[6] = 1'b1;
    wet_timer_en[6] = 1'b0;
    switch_closed[6] = 1'b1;
    cyc(WETC * 2);
    chk("wet held", wet_high[6], 1'b1);
    $display("done wet");
  endtask : t_wet

  initial begin
    rst_n = 1'b0;
    wake_n = 1'b1;
    ext_int_n = 1'b1;
    vdd_present = 1'b1;
    over_temp = 1'b0;
    switch_closed = '0;
    int_enable = '1;
    metallic = '0;
    wet_timer_en = '1;
    high_current_cfg = '1;
    n_mismatch = 0;
    checked = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(5);
    t_frames();
    t_int_timer();
    t_scan();
    t_wake();
    t_thermal();
    t_wet();
    conclude();
  end
endmodule : tb
